// ==== shared/cvlc_consts.vh ====
// Register offsets, field positions, reset values and scaling for the coil voltage limit check
`ifndef CVLC_CONSTS_VH
`define CVLC_CONSTS_VH
`define CVLC_ADDR_W 7
`define CVLC_OFS_LOWER_A 7'h0E
`define CVLC_OFS_UPPER 7'h0F
`define CVLC_FIELD_MSB 10
`define CVLC_FIELD_LSB 1
`define CVLC_LOWER_A_RESET 10'h000
`define CVLC_UPPER_RESET 10'h3FF
`define CVLC_FULL_SCALE_MV 28000
`endif

// ==== rtl/cvlc_compare.v ====
// Threshold comparison stage producing the below and above limit flags
module cvlc_compare (
  input wire [9:0] value_i,
  input wire [9:0] lower_i,
  input wire [9:0] upper_i,
  output wire below_o,
  output wire above_o
);
  // Strict comparisons: equality sets neither flag
  assign below_o = (value_i < lower_i);
  assign above_o = (value_i > upper_i);
endmodule

// ==== rtl/cvlc_limit_check.v ====
// Coil voltage threshold registers and limit flag logic
`include "cvlc_consts.vh"
module cvlc_limit_check (
  input wire mclk_i,
  input wire reset_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [6:0] reg_addr_i,
  input wire [15:0] reg_wdata_i,
  output reg [15:0] reg_rdata_o,
  input wire meas_done_i,
  input wire [9:0] meas_value_i,
  output reg below_limit_a_flag_o,
  output reg above_limit_flag_o,
  output reg flags_valid_o
);
  // Timing seen from the register side:
  // a strobe is taken at the rising edge at which it is high, with its offset and data.
  // Read data appears one edge later and stands until the next read strobe.
  // A measurement strobe updates both flags one edge later; they stand until the next one.
  // A threshold write and a measurement at one edge: the compare sees the old threshold,
  // because it reads the register outputs, never their next values.
  // All strobes come from logic on this clock, so no synchroniser sits in front of them.
  // Serial framing and parity checking live outside this block.

  // Threshold storage and the values they take at the next edge
  reg [9:0] lower_threshold_a_field_reg;
  reg [9:0] lower_threshold_a_field_next;
  reg [9:0] upper_threshold_field_reg;
  reg [9:0] upper_threshold_field_next;

  // Read data at the next edge; the port itself is the register
  reg [15:0] reg_rdata_next;

  // Flag values at the next edge; the ports themselves are the registers
  reg below_limit_a_flag_next;
  reg above_limit_flag_next;
  reg flags_valid_next;

  // Offset decode and qualified strobes
  wire sel_lower_a;
  wire sel_upper;
  wire wr_lower_a;
  wire wr_upper;
  wire rd_lower_a;
  wire rd_upper;

  // Threshold field taken from the write word
  wire [9:0] wdata_field;

  // Read words with reserved bits and the parity slot at zero
  wire [15:0] lower_a_word;
  wire [15:0] upper_word;

  // Comparison results against the thresholds held now
  wire below_now;
  wire above_now;

  // Loop index for building the read words
  genvar gi;

  // Address decode shared by reads and writes
  function hit;
    input [6:0] addr;
    input [6:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  // Offset decode, used by both the write and the read path
  assign sel_lower_a = hit(reg_addr_i, `CVLC_OFS_LOWER_A);
  assign sel_upper = hit(reg_addr_i, `CVLC_OFS_UPPER);

  // Writes act only on a decoded offset; others are dropped
  assign wr_lower_a = reg_wr_i & sel_lower_a;
  assign wr_upper = reg_wr_i & sel_upper;

  // Reads of a decoded offset pick that word; others return zero
  assign rd_lower_a = reg_rd_i & sel_lower_a;
  assign rd_upper = reg_rd_i & sel_upper;

  // Reserved bits and parity of the write word are never stored
  assign wdata_field = reg_wdata_i[`CVLC_FIELD_MSB:`CVLC_FIELD_LSB];

  // Read word layout: field in bits 10..1, everything else zero
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_word
      if ((gi >= `CVLC_FIELD_LSB) && (gi <= `CVLC_FIELD_MSB)) begin : g_field
        assign lower_a_word[gi] = lower_threshold_a_field_reg[gi - `CVLC_FIELD_LSB];
        assign upper_word[gi] = upper_threshold_field_reg[gi - `CVLC_FIELD_LSB];
      end else begin : g_zero
        assign lower_a_word[gi] = 1'b0;
        assign upper_word[gi] = 1'b0;
      end
    end
  endgenerate

  // Comparison against the thresholds held before this edge's write
  // Feeding register outputs, not next values, keeps a same-edge write out of it
  cvlc_compare u_cmp (
    .value_i(meas_value_i),
    .lower_i(lower_threshold_a_field_reg),
    .upper_i(upper_threshold_field_reg),
    .below_o(below_now),
    .above_o(above_now)
  );

  // Lower threshold A next value
  always @* begin
    lower_threshold_a_field_next = lower_threshold_a_field_reg;
    if (wr_lower_a) begin
      lower_threshold_a_field_next = wdata_field;
    end
  end

  // Upper threshold next value
  always @* begin
    upper_threshold_field_next = upper_threshold_field_reg;
    if (wr_upper) begin
      upper_threshold_field_next = wdata_field;
    end
  end

  // Read data next value; it stands until the next read strobe
  always @* begin
    reg_rdata_next = reg_rdata_o;
    if (rd_lower_a) begin
      reg_rdata_next = lower_a_word;
    end else if (rd_upper) begin
      reg_rdata_next = upper_word;
    end else if (reg_rd_i) begin
      reg_rdata_next = 16'h0000;
    end
  end

  // Below flag next value: set when the new code is under threshold A
  always @* begin
    below_limit_a_flag_next = below_limit_a_flag_o;
    if (meas_done_i) begin
      below_limit_a_flag_next = below_now;
    end
  end

  // Above flag next value: set when the new code exceeds the upper threshold
  always @* begin
    above_limit_flag_next = above_limit_flag_o;
    if (meas_done_i) begin
      above_limit_flag_next = above_now;
    end
  end

  // Valid goes high with the first measurement and stays until reset
  always @* begin
    flags_valid_next = flags_valid_o;
    if (meas_done_i) begin
      flags_valid_next = 1'b1;
    end
  end

  // Lower threshold A register
  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      lower_threshold_a_field_reg <= `CVLC_LOWER_A_RESET;
    end else begin
      lower_threshold_a_field_reg <= lower_threshold_a_field_next;
    end
  end

  // Upper threshold register
  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      upper_threshold_field_reg <= `CVLC_UPPER_RESET;
    end else begin
      upper_threshold_field_reg <= upper_threshold_field_next;
    end
  end

  // Read data register
  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      reg_rdata_o <= 16'h0000;
    end else begin
      reg_rdata_o <= reg_rdata_next;
    end
  end

  // Below limit A flag register
  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      below_limit_a_flag_o <= 1'b0;
    end else begin
      below_limit_a_flag_o <= below_limit_a_flag_next;
    end
  end

  // Above limit flag register
  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      above_limit_flag_o <= 1'b0;
    end else begin
      above_limit_flag_o <= above_limit_flag_next;
    end
  end

  // Flags valid register
  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      flags_valid_o <= 1'b0;
    end else begin
      flags_valid_o <= flags_valid_next;
    end
  end
endmodule

// ==== verification/cvlc_limit_check_properties.sv ====
// Port checker for the coil voltage limit check
module cvlc_limit_check_properties(input wire mclk_i,input wire reset_i,input wire reg_rd_i,
  input wire meas_done_i,input wire [6:0] reg_addr_i,input wire [15:0] reg_rdata_o,
  input wire [9:0] meas_value_i,input wire below_limit_a_flag_o,input wire above_limit_flag_o,
  input wire flags_valid_o);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  property p_rsv; reg_rd_i |=> reg_rdata_o[15:11]==5'h0 && !reg_rdata_o[0]; endproperty
  a_rsv: assert property(p_rsv) else $error("reserved bits set");
  property p_unm; reg_rd_i && reg_addr_i>7'h0F |=> reg_rdata_o==16'h0; endproperty
  a_unm: assert property(p_unm) else $error("unmapped read");
  property p_lo; meas_done_i && meas_value_i==10'h0 |=> !above_limit_flag_o; endproperty
  a_lo: assert property(p_lo) else $error("zero above");
  property p_hi; meas_done_i && meas_value_i==10'h3FF |=> !below_limit_a_flag_o; endproperty
  a_hi: assert property(p_hi) else $error("full below");
  property p_hold; !meas_done_i |=> $stable({below_limit_a_flag_o,above_limit_flag_o}); endproperty
  a_hold: assert property(p_hold) else $error("flag moved");
  property p_val; meas_done_i |=> flags_valid_o; endproperty
  a_val: assert property(p_val) else $error("no valid");
endmodule
bind cvlc_limit_check cvlc_limit_check_properties u_chk(.mclk_i(mclk_i),.reset_i(reset_i),
  .reg_rd_i(reg_rd_i),.meas_done_i(meas_done_i),.reg_addr_i(reg_addr_i),.reg_rdata_o(reg_rdata_o),
  .meas_value_i(meas_value_i),.below_limit_a_flag_o(below_limit_a_flag_o),
  .above_limit_flag_o(above_limit_flag_o),.flags_valid_o(flags_valid_o));

// ==== verification/cvlc_meas_src.sv ====
// Registered measurement source
module cvlc_meas_src(input wire c_i,input wire go_i,input wire [9:0] v_i,output reg done_o,
  output reg [9:0] val_o);
  timeunit 1ns; timeprecision 1ns;
  // One code per pulse, scrambled after
  always @(posedge c_i) begin done_o<=go_i; val_o<=go_i?v_i:~val_o; end
endmodule

// ==== verification/cvlc_limit_check_tb.sv ====
// Bench for the coil voltage limit check
module cvlc_limit_check_tb;
  timeunit 1ns; timeprecision 1ns;
  reg mclk_i=0,reset_i=1,wr=0,rd=0,go=0; reg [6:0] ad=0; reg [15:0] wd=0;
  reg [9:0] v=0,lo=0,up=10'h3FF; reg [31:0] s=97354; integer n_mismatch=0,n_compared=0,i;
  wire [15:0] rdat; wire dn,bl,ab,fv; wire [9:0] mv;
  cvlc_meas_src u_src(.c_i(mclk_i),.go_i(go),.v_i(v),.done_o(dn),.val_o(mv));
  cvlc_limit_check u_dut(.mclk_i(mclk_i),.reset_i(reset_i),.reg_wr_i(wr),.reg_rd_i(rd),
    .reg_addr_i(ad),.reg_wdata_i(wd),.reg_rdata_o(rdat),.meas_done_i(dn),.meas_value_i(mv),
    .below_limit_a_flag_o(bl),.above_limit_flag_o(ab),.flags_valid_o(fv));
  initial forever #5 mclk_i=~mclk_i;
  function [31:0] xs(input [31:0] x); xs=x^(x<<13); xs=xs^(xs>>17); xs=xs^(xs<<5); endfunction
  // Compare of register read data
  task chk_reg(input string nm,input [15:0] e,input [15:0] g); #1 n_compared++;
    if(g!==e) begin n_mismatch++; $display("[FAIL] %s exp %h got %h",nm,e,g); end endtask
  // Compare of valid, below and above flags
  task chk_flg(input string nm,input [2:0] e,input [2:0] g); #1 n_compared++;
    if(g!==e) begin n_mismatch++; $display("[FAIL] %s exp %b got %b",nm,e,g); end endtask
  task acc(input w,input [6:0] a,input [15:0] d); @(posedge mclk_i); wr<=w; rd<=!w; ad<=a; wd<=d;
    @(posedge mclk_i); wr<=0; rd<=0; @(posedge mclk_i); endtask
  task ms(input [9:0] x); @(posedge mclk_i); go<=1; v<=x; @(posedge mclk_i); go<=0;
    repeat(2) @(posedge mclk_i); chk_flg("flags",{1'b1,x<lo,x>up},{fv,bl,ab}); endtask
  // Measurement and lower A write taken at one edge; the old threshold decides
  task mw(input [9:0] x,input [9:0] nl); @(posedge mclk_i); go<=1; v<=x;
    @(posedge mclk_i); go<=0; wr<=1; ad<=7'h0E; wd<={5'h0,nl,1'b0};
    @(posedge mclk_i); wr<=0; @(posedge mclk_i);
    chk_flg("flags_same_edge",{1'b1,x<lo,x>up},{fv,bl,ab}); lo=nl; endtask
  task finish_test; $display("compared %0d mismatches %0d",n_compared,n_mismatch);
    if(n_mismatch==0&&n_compared>0) $display("NO MISMATCHES"); else $display("MISMATCHES SEEN");
    $finish; endtask
  // Reset, defaults, then random thresholds with edge measurements
  initial begin
    repeat(5) @(posedge mclk_i); reset_i<=0;
    chk_flg("flags_reset",3'b000,{fv,bl,ab});
    acc(0,7'h0E,0); chk_reg("lower_a",16'h0,rdat);
    acc(0,7'h0F,0); chk_reg("upper",16'h07FE,rdat);
    ms(10'h0); ms(10'h3FF);
    for(i=0;i<40;i++) begin
      s=xs(s); lo=s[9:0]; up=s[19:10];
      acc(1,7'h0E,{s[31:27],lo,1'b1}); acc(1,7'h0F,{5'h1F,up,1'b1});
      acc(0,7'h0E,0); chk_reg("lower_a",{5'h0,lo,1'b0},rdat);
      acc(0,7'h0F,0); chk_reg("upper",{5'h0,up,1'b0},rdat);
      ms(lo-s[31]); ms(up+s[30]); ms(s[29:20]);
      mw(lo,lo+10'h1);
      ms(lo-10'h1);
    end
    acc(0,7'h10,0); chk_reg("unmapped",16'h0,rdat);
    // Reset in mid-run brings back defaults
    @(posedge mclk_i); reset_i<=1; repeat(2) @(posedge mclk_i); reset_i<=0; lo=0; up=10'h3FF;
    chk_flg("flags_reset",3'b000,{fv,bl,ab});
    acc(0,7'h0F,0); chk_reg("upper_reset",16'h07FE,rdat);
    acc(0,7'h0E,0); chk_reg("lower_a_reset",16'h0,rdat);
    ms(10'h200);
    finish_test;
  end
endmodule
